// ==== rtl/retry_channel.sv ====
`include "switch_fault_params.svh"

module retry_channel
    import switch_fault_pkg::*;
#(
    parameter int RETRY_CYCLES = `AUTORETRY_CYCLES,
    parameter int RETRY_LIMIT = `RETRY_LIMIT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic command,
    input wire logic fault_now,
    input wire logic retry_request,
    input wire logic retry_disable,
    input wire logic counter_reset,
    input wire logic fault_clear,
    output logic latched,
    output logic inrush_restart
);
    localparam int TW = $clog2(RETRY_CYCLES + 1);
    localparam int CW = $clog2(RETRY_LIMIT + 1);

    channel_state_e state_q;
    logic [TW-1:0] timer_q;
    logic [CW-1:0] count_q;
    logic command_q;
    logic command_rise;
    logic timer_done;

    assign command_rise = command & ~command_q;
    assign timer_done = (timer_q == TW'(RETRY_CYCLES - 1));
    assign latched = (state_q != CH_ON);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            command_q <= 1'b0;
        end else begin
            command_q <= command;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= CH_ON;
        end else if (fault_clear) begin
            state_q <= CH_ON;
        end else begin
            unique case (state_q)
                CH_ON: begin
                    if (command && fault_now) begin
                        state_q <= CH_LATCHED;
                    end
                end
                CH_LATCHED: begin
                    if (command_rise && !fault_now) begin
                        state_q <= CH_ON;
                    end else if (retry_request && !retry_disable && count_q < CW'(RETRY_LIMIT)) begin
                        state_q <= CH_WAIT_RETRY;
                    end
                end
                CH_WAIT_RETRY: begin
                    if (command_rise && !fault_now) begin
                        state_q <= CH_ON;
                    end else if (timer_done) begin
                        state_q <= fault_now ? CH_LATCHED : CH_ON;
                    end
                end
                default: begin
                    state_q <= CH_LATCHED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_q <= '0;
        end else if (state_q == CH_WAIT_RETRY && !timer_done) begin
            timer_q <= timer_q + TW'(1);
        end else begin
            timer_q <= '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (counter_reset || fault_clear) begin
            count_q <= '0;
        end else if (state_q == CH_WAIT_RETRY && timer_done) begin
            count_q <= count_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inrush_restart <= 1'b0;
        end else begin
            inrush_restart <= (state_q == CH_WAIT_RETRY) && timer_done && !fault_clear;
        end
    end
endmodule

// ==== rtl/switch_fault_autoretry_logic.sv ====
`include "switch_fault_params.svh"

module switch_fault_autoretry_logic
    import switch_fault_pkg::*;
#(
    parameter int NOUT = `OUTPUT_COUNT,
    parameter int RETRY_CYCLES = `AUTORETRY_CYCLES,
    parameter int LED_CYCLES = `LED_CHECK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic overvoltage_detect,
    input wire logic undervoltage_detect,
    input wire logic clamp_detect,
    input wire logic logic_supply_fail,
    input wire logic power_on_reset,
    input wire logic wake_reset_in,
    input wire logic temp_prewarn_detect,
    input wire logic [NOUT-1:0] overcurrent_detect,
    input wire logic [NOUT-1:0] overtemperature_detect,
    input wire logic [NOUT-1:0] supply_short_detect,
    input wire logic [NOUT-1:0] off_open_load_detect,
    input wire logic [NOUT-1:0] on_open_load_detect,
    input wire logic [NOUT-1:0] gate_low,
    input wire logic fail_safe_mode,
    input wire logic overvoltage_protect_disable,
    input wire logic retry_disable,
    input wire logic supply_fail_enable,
    input wire logic sense_output_enable,
    input wire logic [1:0] sense_output_select,
    input wire logic [NOUT-1:0] supply_short_detect_disable,
    input wire logic [NOUT-1:0] off_open_load_disable,
    input wire logic [NOUT-1:0] on_open_load_disable,
    input wire logic [NOUT-1:0] led_open_load_select,
    input wire logic [NOUT*`DUTY_WIDTH-1:0] duty_code,
    input wire logic [NOUT-1:0] output_command,
    input wire logic status_read_done,
    output logic [NOUT-1:0] high_side_outputs,
    output logic fault_flag_pin,
    output logic current_sense_output,
    output logic register_reset,
    output logic [NOUT-1:0] inrush_restart,
    output logic overvoltage_flag,
    output logic undervoltage_flag,
    output logic temp_prewarn_flag,
    output logic [NOUT-1:0] overcurrent_flag,
    output logic [NOUT-1:0] overtemperature_flag,
    output logic [NOUT-1:0] supply_short_flag,
    output logic [NOUT-1:0] off_open_load_flag,
    output logic [NOUT-1:0] on_open_load_flag
);
    localparam int LW = $clog2(LED_CYCLES + 1);

    // Pin inputs: three stages, a change is taken once stages two and three agree
    logic [`SYNC_WIDTH-1:0] pins, s1_q, s2_q, s3_q, filt_q;

    assign pins = {overvoltage_detect, undervoltage_detect, clamp_detect, logic_supply_fail,
                   power_on_reset, wake_reset_in, temp_prewarn_detect, overcurrent_detect,
                   overtemperature_detect, supply_short_detect, off_open_load_detect,
                   on_open_load_detect, gate_low};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= `SYNC_RESET;
            s2_q <= `SYNC_RESET;
            s3_q <= `SYNC_RESET;
            filt_q <= `SYNC_RESET;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end

    logic ov_s, uv_s, clamp_s, vdd_fail_s, por_s, wake_s, prewarn_s;
    logic [NOUT-1:0] oc_s, ot_s, short_s, off_ol_s, on_ol_s, gate_low_s;

    assign {ov_s, uv_s, clamp_s, vdd_fail_s, por_s, wake_s, prewarn_s, oc_s, ot_s, short_s,
            off_ol_s, on_ol_s, gate_low_s} = filt_q;

    // zero defaults while logic supply is lost
    logic cfg_zero, overvoltage_protect_disable_eff, retry_dis_eff, sense_en_eff;
    logic [NOUT-1:0] os_dis_eff, oloff_dis_eff, on_open_load_flag_dis_eff, led_sel_eff;

    assign cfg_zero = vdd_fail_s & supply_fail_enable;
    assign overvoltage_protect_disable_eff = overvoltage_protect_disable & ~cfg_zero;
    assign retry_dis_eff = retry_disable & ~cfg_zero;
    assign sense_en_eff = sense_output_enable & ~cfg_zero;
    assign os_dis_eff = supply_short_detect_disable & ~{NOUT{cfg_zero}};
    assign oloff_dis_eff = off_open_load_disable & ~{NOUT{cfg_zero}};
    assign on_open_load_flag_dis_eff = on_open_load_disable & ~{NOUT{cfg_zero}};
    assign led_sel_eff = led_open_load_select & ~{NOUT{cfg_zero}};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            register_reset <= 1'b0;
        end else begin
            register_reset <= cfg_zero;
        end
    end

    // latched fault reset; battery loss alone keeps everything
    logic fault_reset;
    assign fault_reset = (vdd_fail_s & ~uv_s) | por_s;

    logic ov_protect, ov_shutdown;
    assign ov_protect = fail_safe_mode ? wake_s : ~overvoltage_protect_disable_eff;
    assign ov_shutdown = ov_s & ov_protect;

    // Mode change resets the retry counters and latches; a retry-disable toggle resets only the counters
    logic mode_q, retry_dis_q, counter_reset, mode_change;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 1'b0;
            retry_dis_q <= 1'b0;
        end else begin
            mode_q <= fail_safe_mode;
            retry_dis_q <= retry_dis_eff;
        end
    end

    assign mode_change = mode_q ^ fail_safe_mode;
    assign counter_reset = mode_change | (retry_dis_q ^ retry_dis_eff);

    // read clears, a present fault sets in the same cycle and wins
    logic rd;
    assign rd = status_read_done;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overvoltage_flag <= 1'b0;
        end else if (fault_reset) begin
            overvoltage_flag <= 1'b0;
        end else begin
            overvoltage_flag <= ov_s | (overvoltage_flag & ~rd);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            undervoltage_flag <= 1'b0;
        end else if (fault_reset && !uv_s) begin
            undervoltage_flag <= 1'b0;
        end else begin
            undervoltage_flag <= uv_s | (undervoltage_flag & ~rd);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_prewarn_flag <= 1'b0;
        end else begin
            temp_prewarn_flag <= (prewarn_s & ~fail_safe_mode) | (temp_prewarn_flag & ~rd);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overcurrent_flag <= '0;
            overtemperature_flag <= '0;
        end else if (fault_reset) begin
            overcurrent_flag <= '0;
            overtemperature_flag <= '0;
        end else begin
            overcurrent_flag <= oc_s | (overcurrent_flag & ~{NOUT{rd}});
            overtemperature_flag <= ot_s | (overtemperature_flag & ~{NOUT{rd}});
        end
    end

    // Off-state diagnostics only once the gate is really pulled low
    logic [NOUT-1:0] off_ok, short_set, oloff_set;
    assign off_ok = ~high_side_outputs & gate_low_s;
    assign short_set = short_s & off_ok & ~os_dis_eff;
    // off-state open load, also raised by a short
    assign oloff_set = ((off_ol_s & ~oloff_dis_eff) | short_set) & off_ok;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_short_flag <= '0;
            off_open_load_flag <= '0;
        end else begin
            supply_short_flag <= short_set | (supply_short_flag & ~{NOUT{rd}});
            off_open_load_flag <= oloff_set | (off_open_load_flag & ~{NOUT{rd}});
        end
    end

    // LED open-load check timer and on-state sampling per output
    logic [NOUT-1:0] led_check, on_open_load_flag_set, latched, restart, retry_req;

    genvar i;
    generate
        for (i = 0; i < NOUT; i++) begin : g_out
            logic [LW-1:0] led_timer_q;
            logic full_on;
            logic led_run;

            assign full_on = (duty_code[i*`DUTY_WIDTH +: `DUTY_WIDTH] == `DUTY_FULL_ON);
            // check runs only while the output sits fully on
            assign led_run = high_side_outputs[i] & full_on & led_sel_eff[i];
            assign led_check[i] = led_run && (led_timer_q == LW'(LED_CYCLES - 1));

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    led_timer_q <= '0;
                end else if (!led_run || led_check[i]) begin
                    led_timer_q <= '0;
                end else begin
                    led_timer_q <= led_timer_q + LW'(1);
                end
            end

            // bulb mode samples continuously, LED mode per check period
            assign on_open_load_flag_set[i] = on_ol_s[i] & high_side_outputs[i] & ~on_open_load_flag_dis_eff[i]
                                 & (led_sel_eff[i] ? led_check[i] : 1'b1);

            assign retry_req[i] = overcurrent_flag[i] | overtemperature_flag[i] | undervoltage_flag;

            retry_channel #(
                .RETRY_CYCLES(RETRY_CYCLES),
                .RETRY_LIMIT(`RETRY_LIMIT)
            ) u_channel (
                .clk(clk),
                .reset_n(reset_n),
                .command(output_command[i]),
                .fault_now(oc_s[i] | ot_s[i] | uv_s),
                .retry_request(retry_req[i]),
                .retry_disable(retry_dis_eff),
                .counter_reset(counter_reset),
                .fault_clear(fault_reset | mode_change),
                .latched(latched[i]),
                .inrush_restart(restart[i])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            on_open_load_flag <= '0;
        end else begin
            on_open_load_flag <= on_open_load_flag_set | (on_open_load_flag & ~{NOUT{rd}});
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inrush_restart <= '0;
        end else begin
            inrush_restart <= restart;
        end
    end

    // output drive; clamp overrides every turn-off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_side_outputs <= '0;
        end else if (clamp_s) begin
            high_side_outputs <= '1;
        end else begin
            high_side_outputs <= output_command & ~latched & ~{NOUT{ov_shutdown | uv_s}};
        end
    end

    // fault pin, active low; on-state open load never shows here
    logic fault_now;
    assign fault_now = ov_shutdown | uv_s | (|latched) | (|(ot_s & ~output_command))
                       | (|short_set) | (|oloff_set);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_flag_pin <= 1'b1;
        end else begin
            fault_flag_pin <= ~fault_now;
        end
    end

    // sense follows the selected switch, off in fail-safe mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            current_sense_output <= 1'b0;
        end else begin
            current_sense_output <= sense_en_eff & ~fail_safe_mode
                                    & high_side_outputs[sense_output_select];
        end
    end
endmodule

// ==== rtl/switch_fault_params.svh ====
`ifndef SWITCH_FAULT_PARAMS_SVH
`define SWITCH_FAULT_PARAMS_SVH

`define CLK_FREQ_MHZ 50
// Retry and LED check periods are not fixed here; plain defaults
`define AUTORETRY_TIME_US 150
`define LED_CHECK_TIME_US 1000
`define AUTORETRY_CYCLES (`AUTORETRY_TIME_US * `CLK_FREQ_MHZ)
`define LED_CHECK_CYCLES (`LED_CHECK_TIME_US * `CLK_FREQ_MHZ)
`define RETRY_LIMIT 16
`define OUTPUT_COUNT 4
`define DUTY_WIDTH 7
`define DUTY_FULL_ON 7'h7f
`define SYNC_WIDTH 31
`define SYNC_RESET 31'h0000_0000

`endif

// ==== rtl/switch_fault_pkg.sv ====
package switch_fault_pkg;
    typedef enum logic [1:0] {
        CH_ON = 2'b00,
        CH_LATCHED = 2'b01,
        CH_WAIT_RETRY = 2'b10
    } channel_state_e;
endpackage

// ==== test/status_reader_model.sv ====
module status_reader
(
    input wire logic clk,
    output logic status_read_done
);
    timeunit 1ns;
    timeprecision 1ps;

    initial status_read_done = 1'b0;

    // A slow controller may leave any number of idle cycles before its frame
    task automatic read_status(input int lag);
        repeat (lag) @(negedge clk);
        @(negedge clk);
        status_read_done = 1'b1;
        @(negedge clk);
        status_read_done = 1'b0;
    endtask
endmodule

// ==== test/switch_fault_autoretry_logic_monitor.sv ====
module switch_fault_autoretry_logic_monitor
    import switch_fault_pkg::*;
#(
    parameter int NOUT = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic overvoltage_detect,
    input wire logic undervoltage_detect,
    input wire logic clamp_detect,
    input wire logic logic_supply_fail,
    input wire logic power_on_reset,
    input wire logic temp_prewarn_detect,
    input wire logic fail_safe_mode,
    input wire logic overvoltage_protect_disable,
    input wire logic sense_output_enable,
    input wire logic [1:0] sense_output_select,
    input wire logic [NOUT-1:0] supply_short_detect,
    input wire logic [NOUT-1:0] supply_short_detect_disable,
    input wire logic [NOUT-1:0] off_open_load_disable,
    input wire logic [NOUT-1:0] gate_low,
    input wire logic [NOUT-1:0] output_command,
    input wire logic status_read_done,
    input wire logic [NOUT-1:0] high_side_outputs,
    input wire logic fault_flag_pin,
    input wire logic current_sense_output,
    input wire logic [NOUT-1:0] inrush_restart,
    input wire logic overvoltage_flag,
    input wire logic undervoltage_flag,
    input wire logic temp_prewarn_flag,
    input wire logic [NOUT-1:0] supply_short_flag,
    input wire logic [NOUT-1:0] off_open_load_flag
);
    timeunit 1ns;
    timeprecision 1ps;

    // Held conditions are six samples long to cover the input filter latency
    logic calm;
    assign calm = !logic_supply_fail && !power_on_reset && !clamp_detect;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence ov_held;
        (overvoltage_detect && !overvoltage_protect_disable && !fail_safe_mode && calm)[*6];
    endsequence
    sequence uv_held;
        (undervoltage_detect && calm)[*6];
    endsequence
    sequence short_held;
        (supply_short_detect[0] && gate_low[0] && !output_command[0] && !supply_short_detect_disable[0]
            && !off_open_load_disable[0] && calm)[*6];
    endsequence

    chk_ov_shutdown: assert property (ov_held |-> high_side_outputs == '0 && !fault_flag_pin)
        else $error("outputs or fault pin wrong under overvoltage");
    chk_ov_flag_set: assert property ((overvoltage_detect && !fail_safe_mode && calm)[*6] |-> overvoltage_flag)
        else $error("overvoltage flag not set");
    chk_uv_shutdown: assert property (uv_held |->
        high_side_outputs == '0 && !fault_flag_pin && undervoltage_flag)
        else $error("undervoltage response wrong");
    chk_clamp_all_on: assert property (clamp_detect[*6] |-> high_side_outputs == '1)
        else $error("clamp did not switch all outputs on");
    chk_prewarn_set: assert property ((temp_prewarn_detect && !fail_safe_mode && calm)[*6] |-> temp_prewarn_flag)
        else $error("prewarning flag not set");
    chk_prewarn_hold: assert property (calm[*6] ##0 (temp_prewarn_flag && !status_read_done) |=>
        temp_prewarn_flag)
        else $error("prewarning flag dropped without a read");
    chk_read_clear: assert property ((!temp_prewarn_detect)[*6] ##0 status_read_done |=> !temp_prewarn_flag)
        else $error("read did not clear prewarning flag");
    chk_sense_gate: assert property (current_sense_output |->
        $past(sense_output_enable && !fail_safe_mode && high_side_outputs[sense_output_select]))
        else $error("current sense active with its output off");
    chk_inrush_gap: assert property (inrush_restart[0] |=> (!inrush_restart[0])[*8])
        else $error("inrush restart pulses too close");
    chk_short_flags: assert property (short_held |->
        supply_short_flag[0] && off_open_load_flag[0] && !fault_flag_pin)
        else $error("supply short not reported");
endmodule

bind switch_fault_autoretry_logic switch_fault_autoretry_logic_monitor #(.NOUT(NOUT)) mon (.*);

// ==== test/switch_fault_autoretry_logic_tb.sv ====
module switch_fault_autoretry_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, reset_n, overvoltage_detect, undervoltage_detect, clamp_detect, logic_supply_fail;
    logic power_on_reset, wake_reset_in, temp_prewarn_detect, fail_safe_mode, overvoltage_protect_disable;
    logic retry_disable, supply_fail_enable, sense_output_enable, status_read_done;
    logic [1:0] sense_output_select;
    logic [3:0] overcurrent_detect, overtemperature_detect, supply_short_detect, off_open_load_detect;
    logic [3:0] on_open_load_detect, gate_low, supply_short_detect_disable, off_open_load_disable;
    logic [3:0] on_open_load_disable, led_open_load_select, output_command;
    logic [27:0] duty_code;
    logic [3:0] high_side_outputs, inrush_restart, overcurrent_flag, overtemperature_flag;
    logic [3:0] supply_short_flag, off_open_load_flag, on_open_load_flag;
    logic fault_flag_pin, current_sense_output, register_reset;
    logic overvoltage_flag, undervoltage_flag, temp_prewarn_flag;
    int failures = 0;
    int compares = 0;
    int n;

    // Gate follows the drive, so off-state detection sees a real turn-off
    assign gate_low = ~high_side_outputs;

    switch_fault_autoretry_logic #(.RETRY_CYCLES(8), .LED_CYCLES(16)) DUT (.*);
    status_reader mcu (.clk, .status_read_done);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic w(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic rd(input int lag);
        mcu.read_status(lag);
        w(2);
    endtask

    task automatic pulses(output int c);
        c = 0;
        repeat (400) begin
            @(negedge clk);
            c += int'(inrush_restart[0]);
        end
    endtask

    task end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task ov_case;
        output_command = 4'hf;
        w(3);
        overvoltage_detect = 1'b1;
        w(6);
        chk(high_side_outputs, 4'h0);
        chk(fault_flag_pin, 1'b0);
        overvoltage_detect = 1'b0;
        w(6);
        chk(high_side_outputs, 4'hf);
        chk(overvoltage_flag, 1'b1);
        rd(3);
        chk(overvoltage_flag, 1'b0);
        overvoltage_protect_disable = 1'b1;
        overvoltage_detect = 1'b1;
        w(6);
        chk(high_side_outputs, 4'hf);
        rd(0);
        chk(overvoltage_flag, 1'b1);
        overvoltage_detect = 1'b0;
        w(6);
        rd(0);
        chk(overvoltage_flag, 1'b0);
        overvoltage_protect_disable = 1'b0;
    endtask

    task failsafe_case;
        fail_safe_mode = 1'b1;
        wake_reset_in = 1'b1;
        overvoltage_detect = 1'b1;
        w(6);
        chk(high_side_outputs, 4'h0);
        wake_reset_in = 1'b0;
        w(6);
        chk(high_side_outputs, 4'hf);
        overvoltage_detect = 1'b0;
        sense_output_enable = 1'b1;
        sense_output_select = 2'h2;
        w(3);
        chk(current_sense_output, 1'b0);
        fail_safe_mode = 1'b0;
        w(3);
        chk(current_sense_output, 1'b1);
        output_command = 4'hb;
        w(3);
        chk(current_sense_output, 1'b0);
        output_command = 4'hf;
        sense_output_enable = 1'b0;
        w(6);
        rd(0);
    endtask

    task uv_case;
        retry_disable = 1'b1;
        output_command = 4'h0;
        undervoltage_detect = 1'b1;
        w(6);
        chk(fault_flag_pin, 1'b0);
        chk(undervoltage_flag, 1'b1);
        undervoltage_detect = 1'b0;
        w(6);
        chk(fault_flag_pin, 1'b1);
        chk(undervoltage_flag, 1'b1);
        rd(0);
        chk(undervoltage_flag, 1'b0);
        output_command = 4'hf;
        w(3);
        undervoltage_detect = 1'b1;
        w(6);
        undervoltage_detect = 1'b0;
        w(20);
        chk(fault_flag_pin, 1'b0);
        chk(high_side_outputs, 4'h0);
        output_command = 4'h0;
        w(2);
        output_command = 4'hf;
        w(3);
        chk(high_side_outputs, 4'hf);
        chk(fault_flag_pin, 1'b1);
        rd(0);
        retry_disable = 1'b0;
    endtask

    task retry_case;
        overcurrent_detect = 4'h1;
        pulses(n);
        chk(n, 16);
        chk(high_side_outputs, 4'he);
        retry_disable = 1'b1;
        w(2);
        retry_disable = 1'b0;
        pulses(n);
        chk(n, 16);
        overcurrent_detect = 4'h0;
        w(6);
        retry_disable = 1'b1;
        w(2);
        retry_disable = 1'b0;
        w(40);
        chk(high_side_outputs, 4'hf);
        rd(0);
        chk(overcurrent_flag, 4'h0);
    endtask

    task diag_case;
        output_command = 4'h0;
        supply_short_detect = 4'h1;
        w(6);
        chk(supply_short_flag, 4'h1);
        chk(off_open_load_flag, 4'h1);
        chk(fault_flag_pin, 1'b0);
        supply_short_detect = 4'h0;
        w(6);
        chk(fault_flag_pin, 1'b1);
        rd(0);
        chk(supply_short_flag, 4'h0);
        supply_short_detect_disable = 4'h1;
        supply_short_detect = 4'h1;
        w(6);
        chk(supply_short_flag, 4'h0);
        supply_short_detect = 4'h0;
        supply_short_detect_disable = 4'h0;
        w(6);
        rd(0);
        off_open_load_detect = 4'h4;
        w(6);
        rd(0);
        chk(off_open_load_flag, 4'h4);
        off_open_load_detect = 4'h0;
        w(6);
        rd(0);
        chk(off_open_load_flag, 4'h0);
        off_open_load_disable = 4'h4;
        off_open_load_detect = 4'h4;
        w(6);
        chk(off_open_load_flag, 4'h0);
        off_open_load_detect = 4'h0;
        off_open_load_disable = 4'h0;
    endtask

    task onload_case;
        output_command = 4'hf;
        w(3);
        on_open_load_detect = 4'h8;
        w(6);
        chk(on_open_load_flag, 4'h8);
        chk(high_side_outputs, 4'hf);
        chk(fault_flag_pin, 1'b1);
        on_open_load_detect = 4'h0;
        w(6);
        chk(on_open_load_flag, 4'h8);
        rd(0);
        chk(on_open_load_flag, 4'h0);
        on_open_load_disable = 4'h8;
        on_open_load_detect = 4'h8;
        w(6);
        chk(on_open_load_flag, 4'h0);
        on_open_load_disable = 4'h0;
        led_open_load_select = 4'h8;
        duty_code[27:21] = 7'h10;
        w(40);
        chk(on_open_load_flag, 4'h0);
        duty_code[27:21] = 7'h7f;
        w(40);
        chk(on_open_load_flag, 4'h8);
        on_open_load_detect = 4'h0;
        led_open_load_select = 4'h0;
        duty_code = '0;
        w(6);
        rd(0);
    endtask

    task temp_clamp_case;
        temp_prewarn_detect = 1'b1;
        w(6);
        temp_prewarn_detect = 1'b0;
        w(10);
        chk(temp_prewarn_flag, 1'b1);
        rd(0);
        chk(temp_prewarn_flag, 1'b0);
        fail_safe_mode = 1'b1;
        temp_prewarn_detect = 1'b1;
        w(8);
        chk(temp_prewarn_flag, 1'b0);
        temp_prewarn_detect = 1'b0;
        fail_safe_mode = 1'b0;
        output_command = 4'h0;
        clamp_detect = 1'b1;
        w(6);
        chk(high_side_outputs, 4'hf);
        clamp_detect = 1'b0;
        w(6);
        chk(high_side_outputs, 4'h0);
    endtask

    task supply_case;
        retry_disable = 1'b1;
        output_command = 4'h1;
        overtemperature_detect = 4'h1;
        w(6);
        overtemperature_detect = 4'h0;
        w(6);
        chk(overtemperature_flag, 4'h1);
        chk(high_side_outputs, 4'h0);
        logic_supply_fail = 1'b1;
        supply_fail_enable = 1'b1;
        w(6);
        chk(overtemperature_flag, 4'h0);
        chk(register_reset, 1'b1);
        logic_supply_fail = 1'b0;
        supply_fail_enable = 1'b0;
        w(6);
        chk(register_reset, 1'b0);
        chk(high_side_outputs, 4'h1);
        undervoltage_detect = 1'b1;
        w(6);
        chk(undervoltage_flag, 1'b1);
        chk(register_reset, 1'b0);
        power_on_reset = 1'b1;
        undervoltage_detect = 1'b0;
        w(6);
        chk(undervoltage_flag, 1'b0);
        power_on_reset = 1'b0;
    endtask

    initial begin
        reset_n = 1'b0;
        {overvoltage_detect, undervoltage_detect, clamp_detect, logic_supply_fail, power_on_reset} = '0;
        {wake_reset_in, temp_prewarn_detect, fail_safe_mode, overvoltage_protect_disable, retry_disable} = '0;
        {supply_fail_enable, sense_output_enable, sense_output_select, overcurrent_detect} = '0;
        {overtemperature_detect, supply_short_detect, off_open_load_detect, on_open_load_detect} = '0;
        {supply_short_detect_disable, off_open_load_disable, on_open_load_disable} = '0;
        {led_open_load_select, output_command, duty_code} = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        w(2);
        ov_case();
        failsafe_case();
        uv_case();
        retry_case();
        diag_case();
        onload_case();
        temp_clamp_case();
        supply_case();
        end_of_test();
    end

    // Whole sequence needs about 1250 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule
